// [shared/xmem_map.vh]
`ifndef XMEM_MAP_VH
`define XMEM_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_PTR_HIGH     8'h00
`define OFS_PTR_LOW      8'h04
`define OFS_PAGE_SEL     8'h08
`define OFS_IF_CONFIG    8'h0C
`define OFS_STATUS       8'h10
// ----------------------------------------
// Config fields and reset values
// ----------------------------------------
`define CFG_FAE_BIT      6
`define CFG_SEPARATE_BIT 4
`define CFG_MODE_HI      3
`define CFG_MODE_LO      2
`define CFG_ALE_HI       1
`define CFG_ALE_LO       0
`define CFG_RESET        8'h03
`define PAGE_RESET       8'h00
`define PTR_RESET        8'h00
// ----------------------------------------
// Memory modes and address map
// ----------------------------------------
`define MODE_ONCHIP      2'h0
`define MODE_SPLIT_NB    2'h1
`define MODE_SPLIT_B     2'h2
`define MODE_OFFCHIP     2'h3
`define RAM_SIZE_4K      16'h1000
`define RAM_SIZE_2K      16'h0800
`define FIFO_LO          16'h0400
`define FIFO_HI          16'h07FF
// ----------------------------------------
// Timing counts in system clocks
// ----------------------------------------
`define STROBE_CYCLES    4'h3
`define ALE_BASE_CYCLES  4'h1
`endif

// [hdl/fifo_window_port.v]
`include "xmem_map.vh"
// ----------------------------------------
// Handshake into the USB-side FIFO RAM
// ----------------------------------------
module fifo_window_port (
	input  wire        clk,        // System clock
	input  wire        rst,        // Sync reset
	input  wire        start,      // Access request pulse
	input  wire        we,         // Write access
	input  wire [9:0]  addr,       // FIFO word address
	input  wire [7:0]  wdata,      // Write byte
	input  wire        usb_clk,    // USB side clock
	output reg  [7:0]  rdata,      // Read byte
	output reg         done        // Completion pulse
);
	reg [7:0] mem [0:1023];
	reg       req_reg;             // System-side request level
	reg       req_s1, req_s2, req_s3;
	reg       ack_reg;
	reg       ack_s1, ack_s2;
	reg       busy_reg;
	reg [7:0] udata;
	// Request toggles; USB side acts once per toggle, so slow clocks only stretch time
	always @(posedge clk) begin
		if (rst) begin
			req_reg <= 1'b0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			busy_reg <= 1'b0;
			done <= 1'b0;
			rdata <= 8'h00;
		end else begin
			ack_s1 <= ack_reg;
			ack_s2 <= ack_s1;
			done <= 1'b0;
			if (start && !busy_reg) begin
				req_reg <= ~req_reg;
				busy_reg <= 1'b1;
			end else if (busy_reg && (ack_s2 == req_reg)) begin
				busy_reg <= 1'b0;
				rdata <= udata;    // Stable: USB side changed it before ack
				done <= 1'b1;      // R10
			end
		end
	end
	// USB clock domain; addr and wdata held stable by the caller while busy
	always @(posedge usb_clk) begin
		req_s1 <= req_reg;
		req_s2 <= req_s1;
		req_s3 <= req_s2;
		if (req_s2 != req_s3) begin
			if (we)
				mem[addr] <= wdata;
			udata <= mem[addr];
			ack_reg <= req_s2;     // R9
		end
	end
	initial begin
		ack_reg = 1'b0;
		req_s1 = 1'b0;
		req_s2 = 1'b0;
		req_s3 = 1'b0;
		udata = 8'h00;
	end
endmodule // fifo_window_port

// [hdl/onchip_data_ram.v]
`include "xmem_map.vh"
// ----------------------------------------
// On-chip data RAM, one-cycle read
// ----------------------------------------
module onchip_data_ram (
	input  wire        clk,        // System clock
	input  wire        we,         // Write strobe
	input  wire [11:0] addr,       // Byte address
	input  wire [7:0]  wdata,      // Write byte
	output reg  [7:0]  rdata       // Read byte, next cycle
);
	reg [7:0] mem [0:4095];
	// Synchronous RAM; small variant simply never reaches the upper half
	always @(posedge clk) begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end
endmodule // onchip_data_ram

// [hdl/external_data_memory_port.v]
// The AXI4-Lite slave port and the register addresses were decided locally.
`include "xmem_map.vh"
// Function
// R1: On-chip RAM mapped into external data space
// R2: FIFO RAM mappable as general storage
// R3: Pointer form uses full 16-bit pointer
// R4: Byte form uses page select plus index
// R5: Accesses go to data space unless flash
// R6: Software enables FIFO only with fast clock
// R7: FIFO appears at 0x0400 through 0x07FF
// R8: FIFO window hides overlapping memory
// R9: FIFO access runs in USB clock
// R10: FIFO access takes more cycles
// R11: Software uses FIFO registers for packets
// R12: Off-chip signals appear on ports 4-1
// R13: Pins claimed only during off-chip access
// R14: Input pins undriven during off-chip access
// R15: Pin output mode left unchanged
// R16: Software skips strobe pins in crossbar
// R17: Software parks latches at logic one
// R18: Software configures in five ordered steps
// R19: Four memory modes, muxed or separate bus
// R20: Software prefers push-pull pins
// R21: Split modes divide at RAM size
// R22: Instruction held until access completes
module external_data_memory_port #(
	parameter SMALL_RAM = 0                      // 1 selects 2k variant
) (
	input  wire        CLK,           // System clock
	input  wire        RST,           // Sync reset, high
	input  wire        USB_CLK,       // USB side clock
	input  wire        FLASH_WRITE,   // Flash write enabled
	input  wire        XM_REQ,        // Instruction start pulse
	input  wire        XM_WRITE,      // 1 write, 0 read
	input  wire        XM_SHORT,      // 1 byte form, 0 pointer form
	input  wire        XM_IDX_SEL,    // Index register one select
	input  wire [7:0]  IDX0,          // Index register zero
	input  wire [7:0]  IDX1,          // Index register one
	input  wire [7:0]  XM_WDATA,      // CPU write byte
	output reg  [7:0]  XM_RDATA,      // CPU read byte
	output reg         XM_DONE,       // Completion pulse
	output reg         XM_BUSY,       // CPU stall level
	output reg  [7:0]  ADDR_HI_O,     // Port high address lines
	output reg  [7:0]  ADDR_LO_O,     // Port low address lines
	output reg  [7:0]  DATA_O,        // Port data lines
	output reg         DATA_OE,       // Data drivers on
	input  wire [7:0]  DATA_I,        // Port data pins
	output reg         ADDR_OE,       // Address drivers on
	output reg         ALE_O,         // Address latch strobe
	output reg         RD_N_O,        // Read strobe, low
	output reg         WR_N_O,        // Write strobe, low
	output reg         PORT_CLAIM,    // Ports under interface control
	input  wire [31:0] S_AXI_AWADDR,  // Write address
	input  wire        S_AXI_AWVALID, // Write address valid
	output reg         S_AXI_AWREADY, // Write address ready
	input  wire [31:0] S_AXI_WDATA,   // Write data
	input  wire [3:0]  S_AXI_WSTRB,   // Write strobes
	input  wire        S_AXI_WVALID,  // Write data valid
	output reg         S_AXI_WREADY,  // Write data ready
	output reg  [1:0]  S_AXI_BRESP,   // Write response
	output reg         S_AXI_BVALID,  // Write response valid
	input  wire        S_AXI_BREADY,  // Write response ready
	input  wire [31:0] S_AXI_ARADDR,  // Read address
	input  wire        S_AXI_ARVALID, // Read address valid
	output reg         S_AXI_ARREADY, // Read address ready
	output reg  [31:0] S_AXI_RDATA,   // Read data
	output reg  [1:0]  S_AXI_RRESP,   // Read response
	output reg         S_AXI_RVALID,  // Read response valid
	input  wire        S_AXI_RREADY   // Read response ready
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam ST_IDLE  = 3'h0;
	localparam ST_RAM   = 3'h1;
	localparam ST_FIFO  = 3'h2;
	localparam ST_ALE   = 3'h3;
	localparam ST_SETUP = 3'h4;
	localparam ST_STRB  = 3'h5;
	localparam ST_HOLD  = 3'h6;

	reg [7:0]  ptr_high_reg;
	reg [7:0]  ptr_low_reg;
	reg [7:0]  page_reg;
	reg [7:0]  cfg_reg;
	reg [2:0]  state_reg;
	reg [15:0] addr_reg;
	reg [7:0]  wbyte_reg;
	reg        write_reg;
	reg [3:0]  cnt_reg;
	reg [7:0]  din_s1, din_s2;
	reg        aw_held, w_held;
	reg [31:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0]  w_strb_reg;

	wire [7:0] ram_rdata;
	wire [7:0] fifo_rdata;
	wire       fifo_done;
	wire       fifo_start;
	wire       ram_we;

	// ----------------------------------------
	// Address decode helpers
	// ----------------------------------------
	// Effective address from either instruction form
	function [15:0] eff_addr;
		input        short_form;
		input [7:0]  hi_ptr;
		input [7:0]  lo_ptr;
		input [7:0]  page;
		input [7:0]  idx;
		begin
			if (short_form)
				eff_addr = {page, idx};       // R4
			else
				eff_addr = {hi_ptr, lo_ptr};  // R3
		end
	endfunction

	// Target: 0 on-chip, 1 FIFO, 2 off-chip
	function [1:0] target;
		input [15:0] a;
		input [1:0]  mode;
		input        fae;
		input        small_ram;
		reg   [15:0] size;
		begin
			size = small_ram ? `RAM_SIZE_2K : `RAM_SIZE_4K;
			if (fae && a >= `FIFO_LO && a <= `FIFO_HI)
				target = 2'h1;                // R7 R8
			else if (mode == `MODE_ONCHIP)
				target = 2'h0;                // R1
			else if (mode == `MODE_OFFCHIP)
				target = 2'h2;
			else if (a < size)
				target = 2'h0;                // R21
			else
				target = 2'h2;                // R21
		end
	endfunction

	wire [7:0]  idx_sel = XM_IDX_SEL ? IDX1 : IDX0;
	wire [15:0] req_addr = eff_addr(XM_SHORT, ptr_high_reg, ptr_low_reg, page_reg, idx_sel);
	wire [1:0]  req_tgt = target(req_addr, cfg_reg[`CFG_MODE_HI:`CFG_MODE_LO],
		cfg_reg[`CFG_FAE_BIT], SMALL_RAM != 0);
	wire        start_ok = XM_REQ && !FLASH_WRITE && (state_reg == ST_IDLE);  // R5
	wire [11:0] ram_addr = SMALL_RAM != 0 ? {1'b0, req_addr[10:0]} : req_addr[11:0];

	// Alias: on-chip only wraps every address outside an enabled FIFO window into the RAM
	assign ram_we = start_ok && (req_tgt == 2'h0) && XM_WRITE;
	assign fifo_start = start_ok && (req_tgt == 2'h1);

	onchip_data_ram u_ram (
		.clk   (CLK),
		.we    (ram_we),
		.addr  (ram_addr),
		.wdata (XM_WDATA),
		.rdata (ram_rdata)
	);

	fifo_window_port u_fifo (
		.clk     (CLK),
		.rst     (RST),
		.start   (fifo_start),
		.we      (write_reg),
		.addr    (addr_reg[9:0]),
		.wdata   (wbyte_reg),
		.usb_clk (USB_CLK),
		.rdata   (fifo_rdata),
		.done    (fifo_done)
	);

	// ----------------------------------------
	// Access sequencer
	// ----------------------------------------
	// FIFO start and addr_reg load on the same edge, so the port sees addr before the USB edge
	always @(posedge CLK) begin
		if (RST) begin
			state_reg <= ST_IDLE;
			addr_reg <= 16'h0000;
			wbyte_reg <= 8'h00;
			write_reg <= 1'b0;
			cnt_reg <= 4'h0;
			din_s1 <= 8'h00;
			din_s2 <= 8'h00;
			XM_RDATA <= 8'h00;
			XM_DONE <= 1'b0;
			XM_BUSY <= 1'b0;
			ADDR_HI_O <= 8'h00;
			ADDR_LO_O <= 8'h00;
			DATA_O <= 8'h00;
			DATA_OE <= 1'b0;
			ADDR_OE <= 1'b0;
			ALE_O <= 1'b0;
			RD_N_O <= 1'b1;
			WR_N_O <= 1'b1;
			PORT_CLAIM <= 1'b0;
		end else begin
			din_s1 <= DATA_I;
			din_s2 <= din_s1;
			XM_DONE <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start_ok) begin
						addr_reg <= req_addr;
						wbyte_reg <= XM_WDATA;
						write_reg <= XM_WRITE;
						XM_BUSY <= 1'b1;    // R22
						if (req_tgt == 2'h0)
							state_reg <= ST_RAM;
						else if (req_tgt == 2'h1)
							state_reg <= ST_FIFO;   // R2
						else begin
							// R12 R13 R15
							PORT_CLAIM <= 1'b1;
							ADDR_OE <= 1'b1;
							ADDR_HI_O <= req_addr[15:8];
							ADDR_LO_O <= req_addr[7:0];
							cnt_reg <= `ALE_BASE_CYCLES + {2'b00, cfg_reg[`CFG_ALE_HI:`CFG_ALE_LO]};
							if (cfg_reg[`CFG_SEPARATE_BIT])
								state_reg <= ST_SETUP;  // R19
							else begin
								DATA_OE <= 1'b1;        // Low address on shared lines
								DATA_O <= req_addr[7:0];
								ALE_O <= 1'b1;
								state_reg <= ST_ALE;    // R19
							end
						end
					end
				end
				ST_RAM: begin
					XM_RDATA <= ram_rdata;
					XM_DONE <= 1'b1;
					XM_BUSY <= 1'b0;
					state_reg <= ST_IDLE;
				end
				ST_FIFO: begin
					if (fifo_done) begin     // R10
						XM_RDATA <= fifo_rdata;
						XM_DONE <= 1'b1;
						XM_BUSY <= 1'b0;    // R22
						state_reg <= ST_IDLE;
					end
				end
				ST_ALE: begin
					if (cnt_reg == 4'h1) begin
						ALE_O <= 1'b0;
						state_reg <= ST_SETUP;
					end else
						cnt_reg <= cnt_reg - 4'h1;
				end
				ST_SETUP: begin
					// R14
					DATA_OE <= write_reg;
					DATA_O <= wbyte_reg;
					RD_N_O <= write_reg;
					WR_N_O <= ~write_reg;
					cnt_reg <= `STROBE_CYCLES;
					state_reg <= ST_STRB;
				end
				ST_STRB: begin
					if (cnt_reg == 4'h1) begin
						RD_N_O <= 1'b1;
						WR_N_O <= 1'b1;
						state_reg <= ST_HOLD;
					end else
						cnt_reg <= cnt_reg - 4'h1;
				end
				ST_HOLD: begin
					// Sampled byte passed two stages, so it dates from the strobe
					XM_RDATA <= write_reg ? 8'h00 : din_s2;
					DATA_OE <= 1'b0;
					ADDR_OE <= 1'b0;
					PORT_CLAIM <= 1'b0;   // R13
					XM_DONE <= 1'b1;
					XM_BUSY <= 1'b0;      // R22
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// AXI4-Lite register slave
	// ----------------------------------------
	wire wr_fire = aw_held && w_held && !S_AXI_BVALID;

	// Write channel: address and data captured independently, then applied
	always @(posedge CLK) begin
		if (RST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_reg <= 32'h00000000;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'b00;
			ptr_high_reg <= `PTR_RESET;
			ptr_low_reg <= `PTR_RESET;
			page_reg <= `PAGE_RESET;
			cfg_reg <= `CFG_RESET;
		end else begin
			S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
			S_AXI_WREADY <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= 2'b00;
				if (w_strb_reg[0]) begin
					case (aw_addr_reg[7:0])
						`OFS_PTR_HIGH:  ptr_high_reg <= w_data_reg[7:0];  // R3
						`OFS_PTR_LOW:   ptr_low_reg <= w_data_reg[7:0];   // R3
						`OFS_PAGE_SEL:  page_reg <= w_data_reg[7:0];      // R4
						`OFS_IF_CONFIG: cfg_reg <= w_data_reg[7:0] & 8'h5F;  // R19
						`OFS_STATUS:    S_AXI_BRESP <= 2'b00;
						default:        S_AXI_BRESP <= 2'b10;
					endcase
				end
				if (aw_addr_reg[31:8] != 24'h000000 || aw_addr_reg[7:0] > `OFS_STATUS
					|| aw_addr_reg[1:0] != 2'b00)
					S_AXI_BRESP <= 2'b10;
			end
		end
	end

	// Read channel: one-cycle answer after address taken
	always @(posedge CLK) begin
		if (RST) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= 2'b00;
		end else begin
			S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
			if (S_AXI_RVALID && S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= 2'b00;
				case (S_AXI_ARADDR)
					{24'h000000, `OFS_PTR_HIGH}:  S_AXI_RDATA <= {24'h000000, ptr_high_reg};
					{24'h000000, `OFS_PTR_LOW}:   S_AXI_RDATA <= {24'h000000, ptr_low_reg};
					{24'h000000, `OFS_PAGE_SEL}:  S_AXI_RDATA <= {24'h000000, page_reg};
					{24'h000000, `OFS_IF_CONFIG}: S_AXI_RDATA <= {24'h000000, cfg_reg};
					{24'h000000, `OFS_STATUS}:    S_AXI_RDATA <= {26'h0000000, PORT_CLAIM,
						XM_BUSY, 1'b0, state_reg};
					default: begin
						S_AXI_RDATA <= 32'h00000000;
						S_AXI_RRESP <= 2'b10;
					end
				endcase
			end
		end
	end
endmodule // external_data_memory_port

// [testbench/xmem_port_checker.sv]
module xmem_port_checker (
	input logic CLK, RST, FLASH_WRITE, XM_REQ, XM_DONE, XM_BUSY, PORT_CLAIM,
	input logic DATA_OE, ADDR_OE, ALE_O, RD_N_O, WR_N_O,
	input logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_RVALID, S_AXI_RREADY
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------
	// Pin ownership and stall checks
	// ------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// A request counts only when idle and the flash path is off
	sequence s_taken;
		XM_REQ && !XM_BUSY && !XM_DONE && !FLASH_WRITE;
	endsequence
	sequence s_strobe;
		!RD_N_O || !WR_N_O;
	endsequence
	a_pins_released:
		assert property (!PORT_CLAIM |-> !DATA_OE && !ADDR_OE && RD_N_O && WR_N_O)
		else $error("pins driven outside claim");
	a_claim_ends:
		assert property (XM_DONE |=> !PORT_CLAIM)
		else $error("claim kept after done");
	a_read_undriven:
		assert property (!RD_N_O |-> !DATA_OE && WR_N_O)
		else $error("data driven during read");
	a_strobe_addr:
		assert property (s_strobe |-> ADDR_OE && PORT_CLAIM)
		else $error("strobe without address");
	a_write_drives:
		assert property (!WR_N_O |-> DATA_OE)
		else $error("write without data");
	a_ale_quiet:
		assert property (ALE_O |-> DATA_OE && RD_N_O && WR_N_O)
		else $error("latch strobe overlaps access");
	a_take_stall:
		assert property (s_taken |=> XM_BUSY)
		else $error("no stall after request");
	a_done_bound:
		assert property (s_taken |-> ##[2:400] XM_DONE)
		else $error("access never completed");
	a_done_pulse:
		assert property (XM_DONE |=> !XM_DONE)
		else $error("done longer than a cycle");
	a_flash_ignore:
		assert property (FLASH_WRITE && !XM_BUSY && !XM_DONE |=> !XM_BUSY)
		else $error("request taken during flash write");
	a_bvalid_hold:
		assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	a_rvalid_hold:
		assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
		else $error("read response dropped");
endmodule // xmem_port_checker

bind external_data_memory_port xmem_port_checker u_chk (
	.CLK(CLK), .RST(RST), .FLASH_WRITE(FLASH_WRITE), .XM_REQ(XM_REQ), .XM_DONE(XM_DONE),
	.XM_BUSY(XM_BUSY), .PORT_CLAIM(PORT_CLAIM), .DATA_OE(DATA_OE), .ADDR_OE(ADDR_OE),
	.ALE_O(ALE_O), .RD_N_O(RD_N_O), .WR_N_O(WR_N_O), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);

// [testbench/offchip_sram_model.sv]
module offchip_sram_model (
	input  logic       clk,     // System clock
	input  logic       muxed,   // Shared address and data lines
	input  logic [7:0] addr_hi, // High address lines
	input  logic [7:0] addr_lo, // Low address lines
	input  logic [7:0] bus_out, // Data wire level
	input  logic       ale,     // Address latch strobe
	input  logic       rd_n,    // Read strobe
	input  logic       wr_n,    // Write strobe
	output logic [7:0] bus_in   // Byte driven back
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------
	// Byte-wide static memory
	// ------
	logic [7:0]  mem [0:65535];
	logic [7:0]  lat_reg  = 8'h00;
	logic [7:0]  last_reg = 8'h00;
	logic [15:0] ea;
	// Latch low address on the clock so the strobe edge never races the data
	always @(posedge clk) begin
		if (ale)
			lat_reg <= bus_out;
		if (!wr_n)
			mem[ea] <= bus_out;
		if (!rd_n)
			last_reg <= mem[ea];
	end
	assign ea = {addr_hi, muxed ? lat_reg : addr_lo};
	// Released lines show the inverse of the last byte, not a stale copy
	assign bus_in = !rd_n ? mem[ea] : ~last_reg;
endmodule // offchip_sram_model

// [testbench/external_data_memory_port_tb.sv]
`include "xmem_map.vh"
module external_data_memory_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        CLK = 1'h0, RST = 1'h1, USB_CLK = 1'h0, FLASH_WRITE = 1'h0, XM_REQ = 1'h0;
	logic        XM_WRITE = 1'h0, XM_SHORT = 1'h0, XM_IDX_SEL = 1'h0, muxed = 1'h1;
	logic [7:0]  IDX0 = 8'h00, IDX1 = 8'h00, XM_WDATA = 8'h00, XM_RDATA, ADDR_HI_O, ADDR_LO_O;
	logic [7:0]  DATA_O, DATA_I, mem_q;
	logic        XM_DONE, XM_BUSY, DATA_OE, ADDR_OE, ALE_O, RD_N_O, WR_N_O, PORT_CLAIM;
	logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0, S_AXI_RDATA;
	logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, bresp_q;
	integer      n_mismatch = 0, comparisons = 0, on_n = 0, ale_n = 0, claim_n = 0;
	// ------
	// Clocks, wire resolution, monitors
	// ------
	always #5 CLK = ~CLK;
	always #2.3 USB_CLK = ~USB_CLK;
	assign DATA_I = DATA_OE ? DATA_O : mem_q;
	always @(posedge CLK) begin
		if (ALE_O === 1'h1)
			ale_n <= ale_n + 1;
		if (PORT_CLAIM === 1'h1)
			claim_n <= claim_n + 1;
	end
	external_data_memory_port u_dut (.CLK(CLK), .RST(RST), .USB_CLK(USB_CLK),
		.FLASH_WRITE(FLASH_WRITE), .XM_REQ(XM_REQ), .XM_WRITE(XM_WRITE), .XM_SHORT(XM_SHORT),
		.XM_IDX_SEL(XM_IDX_SEL), .IDX0(IDX0), .IDX1(IDX1), .XM_WDATA(XM_WDATA),
		.XM_RDATA(XM_RDATA), .XM_DONE(XM_DONE), .XM_BUSY(XM_BUSY), .ADDR_HI_O(ADDR_HI_O),
		.ADDR_LO_O(ADDR_LO_O), .DATA_O(DATA_O), .DATA_OE(DATA_OE), .DATA_I(DATA_I),
		.ADDR_OE(ADDR_OE), .ALE_O(ALE_O), .RD_N_O(RD_N_O), .WR_N_O(WR_N_O),
		.PORT_CLAIM(PORT_CLAIM), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY));
	offchip_sram_model u_mem (.clk(CLK), .muxed(muxed), .addr_hi(ADDR_HI_O),
		.addr_lo(ADDR_LO_O), .bus_out(DATA_I), .ale(ALE_O), .rd_n(RD_N_O), .wr_n(WR_N_O),
		.bus_in(mem_q));
	// ------
	// Shared tasks
	// ------
	task results;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
			if (n_mismatch == 0 && comparisons > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// A wait that runs out is a mismatch and ends the run
	task hang(input string nm);
		begin
			cmp(nm, 16'h0001, 16'h0000);
			results;
		end
	endtask
	task axw(input logic [7:0] a, input logic [7:0] d);
		integer i;
		logic   got;
		begin
			// Gap edge: ready and valid never assigned twice in one step
			@(posedge CLK);
			got = 1'h0;
			S_AXI_AWADDR <= {24'h0, a};
			S_AXI_WDATA <= {24'h0, d};
			S_AXI_AWVALID <= 1'h1;
			S_AXI_WVALID <= 1'h1;
			S_AXI_BREADY <= 1'h1;
			for (i = 0; i < 50 && !got; i = i + 1) begin
				@(posedge CLK);
				if (S_AXI_AWREADY === 1'h1)
					S_AXI_AWVALID <= 1'h0;
				if (S_AXI_WREADY === 1'h1)
					S_AXI_WVALID <= 1'h0;
				if (S_AXI_BVALID === 1'h1) begin
					got = 1'h1;
					bresp_q = S_AXI_BRESP;
					S_AXI_BREADY <= 1'h0;
				end
			end
			if (!got)
				hang("write response");
		end
	endtask
	task axr(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
		integer i;
		logic   got;
		begin
			// Gap edge: ready and valid never assigned twice in one step
			@(posedge CLK);
			got = 1'h0;
			S_AXI_ARADDR <= {24'h0, a};
			S_AXI_ARVALID <= 1'h1;
			S_AXI_RREADY <= 1'h1;
			for (i = 0; i < 50 && !got; i = i + 1) begin
				@(posedge CLK);
				if (S_AXI_ARREADY === 1'h1)
					S_AXI_ARVALID <= 1'h0;
				if (S_AXI_RVALID === 1'h1) begin
					got = 1'h1;
					q = S_AXI_RDATA;
					r = S_AXI_RRESP;
					S_AXI_RREADY <= 1'h0;
				end
			end
			if (!got)
				hang("read response");
		end
	endtask
	// Form 0 pointer, 1 index zero, 2 index one; the unused source holds a decoy
	task acc(input logic wr, input logic [1:0] f, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] q, output integer n);
		begin
			axw(`OFS_PTR_HIGH, f == 2'h0 ? a[15:8] : ~a[15:8]);
			axw(`OFS_PTR_LOW, f == 2'h0 ? a[7:0] : ~a[7:0]);
			axw(`OFS_PAGE_SEL, f == 2'h0 ? ~a[15:8] : a[15:8]);
			XM_WRITE <= wr;
			XM_SHORT <= f != 2'h0;
			XM_IDX_SEL <= f == 2'h2;
			IDX0 <= f == 2'h2 ? ~a[7:0] : a[7:0];
			IDX1 <= f == 2'h2 ? a[7:0] : ~a[7:0];
			XM_WDATA <= d;
			XM_REQ <= 1'h1;
			@(posedge CLK);
			XM_REQ <= 1'h0;
			n = 0;
			while (XM_DONE !== 1'h1 && n < 300) begin
				@(posedge CLK);
				n = n + 1;
			end
			if (XM_DONE !== 1'h1)
				hang("access done");
			q = XM_RDATA;
		end
	endtask
	task cfg(input logic fae, input logic sep, input logic [1:0] mode);
		begin
			muxed <= !sep;
			axw(`OFS_IF_CONFIG, {1'h0, fae, 1'h0, sep, mode, 2'h1});
		end
	endtask
	// ------
	// Scenarios
	// ------
	task t_regs;
		logic [31:0] q;
		logic [1:0]  r;
		begin
			axr(`OFS_IF_CONFIG, q, r);
			cmp("config reset", 16'h0003, q[15:0]);
			axw(`OFS_IF_CONFIG, 8'hFF);
			cmp("write resp", 16'h0000, {14'h0, bresp_q});
			axw(8'h40, 8'h00);
			cmp("unmapped write resp", 16'h0002, {14'h0, bresp_q});
			axr(`OFS_IF_CONFIG, q, r);
			cmp("config unused bits", 16'h005F, q[15:0]);
			axr(8'h40, q, r);
			cmp("unmapped resp", 16'h0002, {14'h0, r});
			FLASH_WRITE <= 1'h1;
			XM_REQ <= 1'h1;
			@(posedge CLK);
			XM_REQ <= 1'h0;
			repeat (4) @(posedge CLK);
			cmp("busy in flash write", 16'h0000, {15'h0, XM_BUSY});
			FLASH_WRITE <= 1'h0;
			$display("test regs done");
		end
	endtask
	task t_onchip;
		logic [7:0]  q;
		logic [1:0]  k;
		logic [15:0] a;
		integer      n;
		begin
			cfg(1'h0, 1'h0, `MODE_ONCHIP);
			for (k = 2'h0; k < 2'h3; k = k + 2'h1) begin
				a = 16'h0FFF - 16'h0555 * k;
				acc(1'h1, k, a, {6'h0C, k}, q, n);
				acc(1'h0, k == 2'h2 ? 2'h0 : k + 2'h1, a, 8'h00, q, n);
				cmp("onchip data", {8'h0, 6'h0C, k}, {8'h0, q});
			end
			on_n = n;
			acc(1'h0, 2'h0, 16'h1FFF, 8'h00, q, n);
			cmp("onchip alias", 16'h0030, {8'h0, q});
			$display("test onchip done");
		end
	endtask
	task t_fifo;
		logic [7:0] q;
		integer     n;
		begin
			acc(1'h1, 2'h0, 16'h0500, 8'hA5, q, n);
			cfg(1'h1, 1'h0, `MODE_ONCHIP);
			acc(1'h1, 2'h1, 16'h07FF, 8'h5A, q, n);
			acc(1'h1, 2'h0, 16'h0500, 8'h3C, q, n);
			acc(1'h0, 2'h2, 16'h0500, 8'h00, q, n);
			cmp("fifo data", 16'h003C, {8'h0, q});
			cmp("fifo slower", 16'h0001, {15'h0, n > on_n});
			acc(1'h0, 2'h0, 16'h07FF, 8'h00, q, n);
			cmp("fifo top", 16'h005A, {8'h0, q});
			cfg(1'h0, 1'h0, `MODE_ONCHIP);
			acc(1'h0, 2'h0, 16'h0500, 8'h00, q, n);
			cmp("ram under fifo", 16'h00A5, {8'h0, q});
			$display("test fifo done");
		end
	endtask
	task t_offchip;
		logic [7:0] q;
		integer     n, i, a0;
		begin
			for (i = 0; i < 2; i = i + 1) begin
				cfg(1'h0, i[0], `MODE_OFFCHIP);
				a0 = ale_n;
				acc(1'h1, 2'h2, 16'h0234, {7'h60, i[0]}, q, n);
				cmp("offchip store", {8'h0, 7'h60, i[0]}, {8'h0, u_mem.mem[16'h0234]});
				cmp("latch width", i[0] ? 16'h0000 : 16'h0002, 16'(ale_n - a0));
				u_mem.mem[16'h4321] = {7'h4B, i[0]};
				acc(1'h0, 2'h0, 16'h4321, 8'h00, q, n);
				cmp("offchip read", {8'h0, 7'h4B, i[0]}, {8'h0, q});
				cmp("claim released", 16'h0000, {15'h0, PORT_CLAIM});
				cmp("strobes parked", 16'h0003, {14'h0, RD_N_O, WR_N_O});
				cfg(1'h0, 1'h1, i[0] ? `MODE_SPLIT_B : `MODE_SPLIT_NB);
				a0 = claim_n;
				acc(1'h1, 2'h0, 16'h0FFE, 8'h11, q, n);
				cmp("below boundary", 16'h0000, 16'(claim_n - a0));
				acc(1'h1, 2'h0, 16'h1000, {7'h11, i[0]}, q, n);
				cmp("above boundary", {8'h0, 7'h11, i[0]}, {8'h0, u_mem.mem[16'h1000]});
			end
			$display("test offchip done");
		end
	endtask
	initial begin
		repeat (10) @(posedge CLK);
		RST <= 1'h0;
		@(posedge CLK);
		t_regs;
		t_onchip;
		t_fifo;
		t_offchip;
		results;
	end
endmodule // external_data_memory_port_tb
